// ### design/ltp_top.sv
`timescale 1ns/1ns
module ltp_top #(
	parameter int HI_BLANK = ltp_pkg::HI_BLANK_CYC,
	parameter int LO_BLANK = ltp_pkg::LO_BLANK_CYC,
	parameter int SSTART   = ltp_pkg::SSTART_CYC
) (
	input  wire logic          mclk_in,
	input  wire logic          sys_rst_in,
	input  wire ltp_pkg::ltp_cmp_t cmp_in,
	input  wire logic          supply_turn_on_level_in,
	input  wire logic          brown_out_in,
	input  wire logic          supply_reset_in,
	input  wire logic          thermal_shutdown_flag_in,
	output logic               gate_drive_output_out,
	output logic               softstart_boosted_bias_current_out,
	output ltp_pkg::ltp_stat_t stat_out
);
	localparam int CW = ltp_pkg::CNT_W;

	ltp_pkg::ltp_state_t state_ff;
	ltp_pkg::ltp_state_t nxt_state;
	logic                latch_ff;
	logic                nxt_latch;
	logic [CW-1:0]       ss_cnt_ff;
	logic [CW-1:0]       nxt_ss_cnt;
	logic                hi_qual;
	logic                lo_qual;

	// Comparators are blind until start is possible, so settling refs
	// cannot trip the latch
	wire ready    = supply_turn_on_level_in && !brown_out_in; // R4
	wire in_ss    = (state_ff == ltp_pkg::LTP_SSTART);
	wire in_run   = (state_ff == ltp_pkg::LTP_RUN);
	wire hi_en    = ready && (in_ss || in_run ||
		state_ff == ltp_pkg::LTP_OFF); // R5
	wire lo_en    = ready && in_run; // R6
	wire ss_done  = (ss_cnt_ff == CW'(SSTART));
	wire clr_ev   = brown_out_in || supply_reset_in; // R3
	wire set_ev   = hi_qual || lo_qual; // R1

	ltp_blank #(.TERM(HI_BLANK), .CNT_W(CW)) u_hi (
		.mclk_in   (mclk_in),
		.sys_rst_in(sys_rst_in),
		.enable_in (hi_en),
		.cross_in  (cmp_in.hi_cross),
		.qual_out  (hi_qual)
	);

	ltp_blank #(.TERM(LO_BLANK), .CNT_W(CW)) u_lo (
		.mclk_in   (mclk_in),
		.sys_rst_in(sys_rst_in),
		.enable_in (lo_en),
		.cross_in  (cmp_in.lo_cross),
		.qual_out  (lo_qual)
	);

	// Clear has priority: a reset-level supply cannot hold a latch
	assign nxt_latch = clr_ev ? 1'b0 : (latch_ff || set_ev); // R1 R3

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			ltp_pkg::LTP_OFF:
				if (ready && !latch_ff && !set_ev &&
					!thermal_shutdown_flag_in)
					nxt_state = ltp_pkg::LTP_SSTART; // R5
			ltp_pkg::LTP_SSTART:
				if (thermal_shutdown_flag_in)
					nxt_state = ltp_pkg::LTP_TSD; // R8
				else if (!ready || latch_ff || set_ev)
					nxt_state = ltp_pkg::LTP_OFF;
				else if (ss_done)
					nxt_state = ltp_pkg::LTP_RUN; // R6
			ltp_pkg::LTP_RUN:
				if (thermal_shutdown_flag_in)
					nxt_state = ltp_pkg::LTP_TSD; // R8
				else if (!ready || latch_ff || set_ev)
					nxt_state = ltp_pkg::LTP_OFF; // R1
			ltp_pkg::LTP_TSD:
				if (!thermal_shutdown_flag_in)
					nxt_state = ltp_pkg::LTP_OFF; // R10
			default:
				nxt_state = ltp_pkg::LTP_OFF;
		endcase
	end

	// Soft-start timer restarts on every entry into soft-start
	assign nxt_ss_cnt = !in_ss ? '0 :
		(ss_done ? ss_cnt_ff : ss_cnt_ff + CW'(1)); // R10

	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			state_ff  <= ltp_pkg::LTP_OFF;
			latch_ff  <= 1'b0;
			ss_cnt_ff <= '0;
		end
		else
		begin
			state_ff  <= nxt_state;
			latch_ff  <= nxt_latch;
			ss_cnt_ff <= nxt_ss_cnt;
		end
	end

	// Drive gated combinationally so thermal trip stops it the same cycle
	assign gate_drive_output_out = (in_ss || in_run) && !latch_ff &&
		!thermal_shutdown_flag_in; // R8
	assign softstart_boosted_bias_current_out = in_ss; // R7
	assign stat_out.gate_drive_en = gate_drive_output_out;
	assign stat_out.boosted_bias  = in_ss;
	assign stat_out.latched_off   = latch_ff;
	// Supply held during thermal shutdown so its state survives
	assign stat_out.supply_keep   = (state_ff == ltp_pkg::LTP_TSD); // R9

	a_latch_sets: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		set_ev && !clr_ev |=> latch_ff) // R1
		else $error("Qualified crossing did not latch");
	a_latch_holds: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		latch_ff && !clr_ev |=> latch_ff) // R3
		else $error("Latch released without brown-out or reset");
	a_latch_clears: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in) clr_ev |=> !latch_ff) // R3
		else $error("Latch not cleared by brown-out or reset");
	a_ignore_unready: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in) !ready |-> !hi_qual && !lo_qual) // R4
		else $error("Comparator qualified before ready");
	a_low_after_ss: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in) !in_run |-> !lo_qual) // R6
		else $error("Low latch evaluated before soft-start end");
	a_boost_in_ss: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in)
		$rose(in_run) |-> $past(softstart_boosted_bias_current_out)) // R7
		else $error("Bias boost not held to the end of soft-start");
	a_tsd_stops: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in)
		thermal_shutdown_flag_in |-> !gate_drive_output_out
		##1 (state_ff == ltp_pkg::LTP_TSD || !in_run)) // R8
		else $error("Drive active during thermal shutdown");
	a_tsd_keeps: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in)
		state_ff == ltp_pkg::LTP_TSD |-> stat_out.supply_keep) // R9
		else $error("Supply dropped in thermal shutdown");
	a_restart_ss: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in)
		$past(state_ff) != ltp_pkg::LTP_SSTART && in_run |->
		$past(in_run)) // R10
		else $error("Run entered without soft-start");
endmodule

// ### design/ltp_pkg.sv
// What this block does
// [R1] Latch off when either window comparator crossing is qualified.
// [R2] Blank high crossings under 50 us, low crossings under 350 us.
// [R3] Clear the off latch only on brown-out or supply reset.
// [R4] Ignore both comparators until the controller is ready to start.
// [R5] Evaluate high latch from turn-on level; switch only if allowed.
// [R6] Evaluate low latch only after soft-start completes.
// [R7] Double thermistor bias current during the whole soft-start.
// [R8] Thermal shutdown stops switching at once, enters off state.
// [R9] Keep supply active during thermal shutdown to retain its state.
// [R10] On thermal recovery, rerun full start-up including soft-start.
// [R11] Blanking counters restart on deassert; latch only at terminal count.
package ltp_pkg;
	localparam int CLK_HZ        = 50000000;
	localparam int HI_BLANK_US   = 50;
	localparam int LO_BLANK_US   = 350;
	localparam int SSTART_US     = 10000;
	localparam int HI_BLANK_CYC  = (HI_BLANK_US * (CLK_HZ / 1000000));
	localparam int LO_BLANK_CYC  = (LO_BLANK_US * (CLK_HZ / 1000000));
	localparam int SSTART_CYC    = (SSTART_US * (CLK_HZ / 1000000));
	localparam int CNT_W         = 20;

	typedef enum logic [3:0] {
		LTP_OFF    = 4'h1,
		LTP_SSTART = 4'h2,
		LTP_RUN    = 4'h4,
		LTP_TSD    = 4'h8
	} ltp_state_t;

	typedef struct packed {
		logic hi_cross;
		logic lo_cross;
	} ltp_cmp_t;

	typedef struct packed {
		logic gate_drive_en;
		logic boosted_bias;
		logic latched_off;
		logic supply_keep;
	} ltp_stat_t;
endpackage

// ### design/ltp_blank.sv
`timescale 1ns/1ns
module ltp_blank #(
	parameter int TERM  = 2500,
	parameter int CNT_W = 20
) (
	input  wire logic mclk_in,
	input  wire logic sys_rst_in,
	input  wire logic enable_in,
	input  wire logic cross_in,
	output logic      qual_out
);
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	wire              at_term = (cnt_ff == CNT_W'(TERM));

	// Restart whenever the crossing goes away or is not evaluated
	assign nxt_cnt = (!enable_in || !cross_in) ? '0 :
		(at_term ? cnt_ff : cnt_ff + CNT_W'(1)); // R11

	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

	// Gated by the live inputs so a counter parked at terminal count
	// cannot report a crossing for one cycle after evaluation stops
	assign qual_out = at_term && enable_in && cross_in; // R2

	a_blank_needs_hold: assert property (@(posedge mclk_in)
		disable iff (sys_rst_in)
		$rose(qual_out) |-> $past(cross_in) && $past(enable_in)) // R11
		else $error("Qualification without a held crossing");
endmodule

// ### verif/ltp_sense.sv
`timescale 1ns/1ns
module ltp_sense (
	input  wire logic         mclk_in,
	input  wire logic         hi_in,
	input  wire logic         lo_in,
	output ltp_pkg::ltp_cmp_t cmp_out
);
	// Comparators answer one clock after the pin moves
	always_ff @(posedge mclk_in)
		cmp_out <= '{hi_cross: hi_in, lo_cross: lo_in};
endmodule

// ### verif/test_ltp_top.sv
`timescale 1ns/1ns
module test_ltp_top;
	localparam int HB = 5;
	localparam int LB = 20;
	localparam int SS = 50;
	logic               mclk_in = 0;
	logic               sys_rst_in = 1;
	logic               hi = 0;
	logic               lo = 0;
	logic               on = 0;
	logic               bo = 0;
	logic               sr = 0;
	logic               thermal_shutdown_flag = 0;
	ltp_pkg::ltp_cmp_t  cmp;
	logic               drv;
	logic               boost;
	ltp_pkg::ltp_stat_t st;
	logic [4:0]         q[$];
	logic [4:0]         e;
	int                 bad_count = 0;
	int                 cmp_count = 0;
	int                 cycles = 0;
	initial forever #10 mclk_in = ~mclk_in;
	ltp_sense i_sense (.mclk_in(mclk_in), .hi_in(hi), .lo_in(lo),
		.cmp_out(cmp));
	ltp_top #(.HI_BLANK(HB), .LO_BLANK(LB), .SSTART(SS)) i_dut (
		.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .cmp_in(cmp),
		.supply_turn_on_level_in(on), .brown_out_in(bo),
		.supply_reset_in(sr), .thermal_shutdown_flag_in(thermal_shutdown_flag),
		.gate_drive_output_out(drv),
		.softstart_boosted_bias_current_out(boost), .stat_out(st));
	task automatic cy(int n);
		repeat (n) @(posedge mclk_in);
	endtask
	// Note {drive, boost, latched, unused, keep}
	task automatic ex(logic [4:0] v);
		@(posedge mclk_in);
		q.push_back(v);
	endtask
	task automatic chk(string n, logic x, logic g);
		cmp_count++;
		if (g !== x)
		begin
			bad_count++;
			$display("ERROR %s exp %b got %b", n, x, g);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(negedge mclk_in)
		if (q.size() > 0)
		begin
			e = q.pop_front();
			chk("drive", e[4], drv);
			chk("drive_en", e[4], st.gate_drive_en);
			chk("boost", e[3], boost);
			chk("boost_st", e[3], st.boosted_bias);
			chk("latched", e[2], st.latched_off);
			chk("keep", e[0], st.supply_keep);
		end
	// Whole sequence needs well under a thousand cycles
	always @(posedge mclk_in)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			final_report();
		end
	end
	initial
	begin
		int n;
		n = $urandom(57);
		cy(12);
		sys_rst_in <= 0;
		hi <= 1;
		cy(HB + 5);
		ex(5'h00);
		hi <= 0;
		on <= 1;
		cy(3);
		ex(5'h18);
		lo <= 1;
		cy(LB + 5);
		ex(5'h18);
		lo <= 0;
		cy(SS);
		ex(5'h10);
		hi <= 1;
		cy(1 + $urandom % (HB - 1));
		hi <= 0;
		cy(3);
		ex(5'h10);
		lo <= 1;
		cy(LB + 5);
		ex(5'h04);
		lo <= 0;
		cy(5);
		ex(5'h04);
		sr <= 1;
		cy(2);
		sr <= 0;
		cy(3);
		ex(5'h18);
		hi <= 1;
		cy(HB + 5);
		ex(5'h04);
		hi <= 0;
		bo <= 1;
		cy(2);
		bo <= 0;
		cy(3);
		ex(5'h18);
		cy(SS + 3);
		thermal_shutdown_flag <= 1;
		ex(5'h03);
		cy(5);
		thermal_shutdown_flag <= 0;
		cy(4);
		ex(5'h18);
		cy(2);
		final_report();
	end
endmodule
